// File: src/cts_digit_action.sv
// Decoder of one arrival-handling digit into cyclic and stop-output flags
`timescale 1ns/100ps
`default_nettype none
module cts_digit_action (
  input  wire logic [3:0] digit,     // Mode digit 0..3
  output logic            cyclic,    // Restart automatically
  output logic            stop_out   // Stop drive output on arrival
);
  import cts_pkg::*;
  always_comb begin
    cyclic   = digit[1];
    stop_out = ~digit[0];
  end
endmodule
`default_nettype wire

// File: src/cts_pkg.sv
// Package of constants for the count and timing supervisor
package cts_pkg;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE       = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_WRAP       = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_DETECT     = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_TARGET     = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT   = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_COUNT      = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_SECONDS    = 12'h024;
  // Reset values and the 9999 value limit
  localparam logic [15:0] RST_MODE   = 16'h0103;
  localparam logic [15:0] RST_WRAP   = 16'h0001;
  localparam logic [15:0] RST_DETECT = 16'h0001;
  localparam logic [15:0] RST_TARGET = 16'h0000;
  localparam logic [15:0] MAX_VALUE  = 16'h270F;
  // Mode field positions (one nibble per decimal digit)
  localparam int MODE_CNT_LSB = 0;
  localparam int MODE_TMR_LSB = 8;
  localparam int DIGIT_W      = 4;
  localparam logic [3:0] DIGIT_MAX = 4'h3;
  // Control bits
  localparam int CTRL_CNT_ARM = 0;
  localparam int CTRL_TMR_ARM = 1;
  // Interrupt status bits
  localparam int IRQ_DETECT  = 0;
  localparam int IRQ_WRAP    = 1;
  localparam int IRQ_TIMER   = 2;
  localparam int IRQ_W       = 3;
  // Timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int SECOND_S     = 1;
  localparam int SEC_CYCLES   = CLK_HZ * SECOND_S;
  typedef enum logic [1:0] {CTS_IDLE, CTS_RUN, CTS_DONE} cts_run_e;
endpackage

// File: src/cts_top.sv
// Count and timing supervisor with APB register access
// Contract
// - Units digit selects count arrival handling
// - Hundreds digit selects timer arrival handling
// - Wrap value from detect value to 9999
// - Detect value from zero to wrap value
// - Count equal wrap: pulse, clear count
// - Count equal detect: hold detect output
// - Clearing at wrap drops detect output
// - Wrap output is one-period pulse only
// - Timer reaches seconds target, runs action
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module cts_top #(
  parameter int SEC_TICKS = cts_pkg::SEC_CYCLES
)(
  input  wire logic                       pclk,       // Clock 100 MHz
  input  wire logic                       presetn,    // Async reset, active low
  input  wire logic                       psel,       // APB select
  input  wire logic                       penable,    // APB enable
  input  wire logic                       pwrite,     // APB write
  input  wire logic [cts_pkg::ADDR_W-1:0] paddr,      // APB byte address
  input  wire logic [31:0]                pwdata,     // APB write data
  output logic      [31:0]                prdata,     // APB read data
  output logic                            pready,     // APB ready
  output logic                            pslverr,    // APB error
  input  wire logic                       count_in,   // Counting pin, asynchronous
  output logic                            detect_out, // Held counter detection
  output logic                            wrap_out,   // Counter reset pulse
  output logic                            run_stop,   // Drive output stop request
  output logic                            irq         // Level interrupt
);
  import cts_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [15:0]       mode, wrap_val, det_val, target;
  logic [15:0]       next_mode, next_wrap_val, next_det_val, next_target;
  logic [IRQ_W-1:0]  irq_stat, irq_mask, next_irq_stat, next_irq_mask;
  logic [15:0]       count, next_count, secs, next_secs;
  logic [31:0]       tick, next_tick;
  cts_run_e          cnt_st, next_cnt_st, tmr_st, next_tmr_st;
  logic              next_detect, next_wrap, cnt_stop, tmr_stop;
  logic              next_cnt_stop, next_tmr_stop;
  logic [2:0]        sync, next_sync;
  logic [31:0]       next_prdata;
  logic              cnt_cyc, cnt_halt, tmr_cyc, tmr_halt;
  logic              wr, rd, hit, edge_q, cnt_ev, wrap_ev, det_ev, tmr_ev;
  logic              arm_cnt, arm_tmr;

  function automatic logic decode_ok(input logic [ADDR_W-1:0] a);
    decode_ok = (a <= OFS_SECONDS) && (a[1:0] == 2'b00);
  endfunction

  cts_digit_action u_cnt_act (
    .digit    (mode[MODE_CNT_LSB +: DIGIT_W]),
    .cyclic   (cnt_cyc),
    .stop_out (cnt_halt)
  );
  cts_digit_action u_tmr_act (
    .digit    (mode[MODE_TMR_LSB +: DIGIT_W]),
    .cyclic   (tmr_cyc),
    .stop_out (tmr_halt)
  );

  ////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped word
  // Read data is loaded at setup so it stands through the access phase
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~penable & ~pwrite;
  assign hit     = decode_ok(paddr);
  assign pslverr = psel & penable & ~hit;
  assign arm_cnt = wr && paddr == OFS_CTRL && pwdata[CTRL_CNT_ARM];
  assign arm_tmr = wr && paddr == OFS_CTRL && pwdata[CTRL_TMR_ARM];

  always_comb begin
    next_mode     = mode;
    next_wrap_val = wrap_val;
    next_det_val  = det_val;
    next_target   = target;
    next_irq_mask = irq_mask;
    next_prdata   = prdata;
    if (wr && hit) begin
      case (paddr)
        OFS_MODE: begin
          // A write with an illegal digit is ignored whole, reserved digits forced to zero
          if (pwdata[3:0] <= DIGIT_MAX && pwdata[11:8] <= DIGIT_MAX) begin
            next_mode = {8'h00, pwdata[7:0] & 8'h0F} | {4'h0, pwdata[11:8], 8'h00};
          end
        end
        OFS_WRAP: begin
          if (pwdata[15:0] >= det_val && pwdata[15:0] <= MAX_VALUE &&
              pwdata[31:16] == 16'h0000) begin
            next_wrap_val = pwdata[15:0];
          end
        end
        OFS_DETECT: begin
          if (pwdata[15:0] <= wrap_val && pwdata[31:16] == 16'h0000) begin
            next_det_val = pwdata[15:0];
          end
        end
        OFS_TARGET: begin
          if (pwdata[15:0] <= MAX_VALUE && pwdata[31:16] == 16'h0000) begin
            next_target = pwdata[15:0];
          end
        end
        OFS_IRQ_MASK: next_irq_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (paddr)
        OFS_MODE:     next_prdata = {16'h0000, mode};
        OFS_WRAP:     next_prdata = {16'h0000, wrap_val};
        OFS_DETECT:   next_prdata = {16'h0000, det_val};
        OFS_TARGET:   next_prdata = {16'h0000, target};
        OFS_STATUS:   next_prdata = {26'h0, tmr_stop, cnt_stop,
                                     tmr_st == CTS_DONE, cnt_st == CTS_DONE,
                                     wrap_out, detect_out};
        OFS_IRQ_STAT: next_prdata = {29'h0, irq_stat};
        OFS_IRQ_MASK: next_prdata = {29'h0, irq_mask};
        OFS_COUNT:    next_prdata = {16'h0000, count};
        OFS_SECONDS:  next_prdata = {16'h0000, secs};
        default:      next_prdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Counter
  // Two flops tame the pin; the third only marks the rising edge
  assign edge_q  = sync[1] & ~sync[2];
  assign cnt_ev  = edge_q && cnt_st == CTS_RUN;
  assign wrap_ev = cnt_ev && (count + 16'h0001) == wrap_val;
  assign det_ev  = cnt_ev && (count + 16'h0001) == det_val && !wrap_ev;

  always_comb begin
    next_sync     = {sync[1:0], count_in};
    next_count    = count;
    next_cnt_st   = cnt_st;
    next_detect   = detect_out;
    next_wrap     = 1'b0;
    next_cnt_stop = cnt_stop;
    if (arm_cnt) begin
      next_cnt_st   = CTS_RUN;
      next_count    = 16'h0000;
      next_detect   = 1'b0;
      next_cnt_stop = 1'b0;
    end else if (cnt_ev) begin
      next_count = count + 16'h0001;
      if (det_ev) begin
        next_detect = 1'b1;
      end
      if (wrap_ev) begin
        next_wrap     = 1'b1;
        next_count    = 16'h0000;
        next_detect   = 1'b0;
        next_cnt_stop = cnt_halt;
        next_cnt_st   = cnt_cyc ? CTS_RUN : CTS_DONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Timer
  // Target is compared every cycle, so target 0 arrives right after arm
  always_comb begin
    next_tick     = tick;
    next_secs     = secs;
    next_tmr_st   = tmr_st;
    next_tmr_stop = tmr_stop;
    tmr_ev        = 1'b0;
    if (arm_tmr) begin
      next_tmr_st   = CTS_RUN;
      next_tick     = 32'h0;
      next_secs     = 16'h0000;
      next_tmr_stop = 1'b0;
    end else if (tmr_st == CTS_RUN) begin
      if (secs >= target) begin
        tmr_ev        = 1'b1;
        next_tmr_stop = tmr_halt;
        next_tmr_st   = tmr_cyc ? CTS_RUN : CTS_DONE;
        next_secs     = 16'h0000;
        next_tick     = 32'h0;
      end else if (tick == 32'(SEC_TICKS - 1)) begin
        next_tick = 32'h0;
        next_secs = secs + 16'h0001;
      end else begin
        next_tick = tick + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over write-one-to-clear
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr && paddr == OFS_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
    end
    next_irq_stat[IRQ_DETECT] = next_irq_stat[IRQ_DETECT] | det_ev;
    next_irq_stat[IRQ_WRAP]   = next_irq_stat[IRQ_WRAP] | wrap_ev;
    next_irq_stat[IRQ_TIMER]  = next_irq_stat[IRQ_TIMER] | tmr_ev;
  end
  assign irq      = |(irq_stat & irq_mask);
  assign run_stop = cnt_stop | tmr_stop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode       <= RST_MODE;
      wrap_val   <= RST_WRAP;
      det_val    <= RST_DETECT;
      target     <= RST_TARGET;
      irq_mask   <= '0;
      irq_stat   <= '0;
      prdata     <= 32'h0000_0000;
      sync       <= 3'h0;
      count      <= 16'h0000;
      cnt_st     <= CTS_RUN;
      detect_out <= 1'b0;
      wrap_out   <= 1'b0;
      cnt_stop   <= 1'b0;
      tick       <= 32'h0;
      secs       <= 16'h0000;
      tmr_st     <= CTS_IDLE;
      tmr_stop   <= 1'b0;
    end else begin
      mode       <= next_mode;
      wrap_val   <= next_wrap_val;
      det_val    <= next_det_val;
      target     <= next_target;
      irq_mask   <= next_irq_mask;
      irq_stat   <= next_irq_stat;
      prdata     <= next_prdata;
      sync       <= next_sync;
      count      <= next_count;
      cnt_st     <= next_cnt_st;
      detect_out <= next_detect;
      wrap_out   <= next_wrap;
      cnt_stop   <= next_cnt_stop;
      tick       <= next_tick;
      secs       <= next_secs;
      tmr_st     <= next_tmr_st;
      tmr_stop   <= next_tmr_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions
  // Arm and arrival in one cycle: arm wins, so guards leave that out
  AST_WRAP_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_out |=> !wrap_out) else $error("wrap pulse longer than one cycle");
  AST_WRAP_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_ev && !arm_cnt |=> wrap_out && count == 16'h0000) else $error("wrap did not clear");
  AST_DET_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_out |-> !detect_out) else $error("detect held past wrap");
  AST_DET_SET: assert property (@(posedge pclk) disable iff (!presetn)
    det_ev && !arm_cnt |=> detect_out) else $error("detect not raised");
  AST_DET_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    detect_out && !$past(detect_out) |-> count == det_val) else $error("detect at wrong count");
  AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    det_val <= wrap_val && wrap_val <= MAX_VALUE) else $error("limits out of order");
  AST_COUNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_ev && !wrap_ev && !arm_cnt |=> count == $past(count) + 16'h0001)
    else $error("count did not advance");
  AST_ONESHOT: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_ev && !cnt_cyc && !arm_cnt |=> cnt_st == CTS_DONE) else $error("one-shot restarted");
  AST_DONE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_st == CTS_DONE && !arm_cnt |=> cnt_st == CTS_DONE && $stable(count))
    else $error("stopped counter moved");
  AST_CNT_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_ev && !arm_cnt |=> cnt_stop == $past(cnt_halt))
    else $error("count arrival action wrong");
  AST_CNT_REARM: assert property (@(posedge pclk) disable iff (!presetn)
    arm_cnt |=> cnt_st == CTS_RUN && count == 16'h0000 && !cnt_stop && !detect_out)
    else $error("counter re-arm incomplete");
  AST_TMR_ONESHOT: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_ev && !tmr_cyc && !arm_tmr |=> tmr_st == CTS_DONE) else $error("timer restarted");
  AST_TMR_REARM: assert property (@(posedge pclk) disable iff (!presetn)
    arm_tmr |=> tmr_st == CTS_RUN && secs == 16'h0000 && !tmr_stop)
    else $error("timer arm incomplete");
  AST_IRQ_TMR: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_ev |=> irq_stat[IRQ_TIMER]) else $error("timer event lost");
  AST_WRAP_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_WRAP && pwdata[15:0] > MAX_VALUE |=> wrap_val == $past(wrap_val))
    else $error("wrap value above limit taken");
  AST_DET_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_DETECT && pwdata[15:0] > wrap_val |=> det_val == $past(det_val))
    else $error("detect value above wrap taken");
  AST_TMR_ACT: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_ev && !arm_tmr |=> tmr_stop == $past(tmr_halt) && secs == 16'h0000)
    else $error("timer arrival action wrong");
  AST_MODE_OK: assert property (@(posedge pclk) disable iff (!presetn)
    mode[3:0] <= DIGIT_MAX && mode[11:8] <= DIGIT_MAX && mode[7:4] == 4'h0)
    else $error("illegal mode digit");
  COV_WRAP: cover property (@(posedge pclk) disable iff (!presetn) wrap_out);
  COV_DET: cover property (@(posedge pclk) disable iff (!presetn) det_ev);
  COV_TMR: cover property (@(posedge pclk) disable iff (!presetn) tmr_ev);
  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) irq);
  COV_DONE: cover property (@(posedge pclk) disable iff (!presetn) cnt_st == CTS_DONE);
endmodule
`default_nettype wire

// File: tb/tb_cts_top.sv
// Self-checking testbench of the count and timing supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_cts_top;
  import cts_pkg::*;
  localparam int TICKS = 10;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              count_in = 1'b0;
  logic              detect_out;
  logic              wrap_out;
  logic              run_stop;
  logic              irq;
  logic              wrap_prev = 1'b0;
  logic [32:0]       q[$];
  logic [31:0]       seed = 32'd2264;
  logic [15:0]       det;
  int                miscompares = 0;
  int                compares = 0;
  int                wraps = 0;
  int                n;
  always #5 pclk = ~pclk;
  cts_top #(.SEC_TICKS(TICKS)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_in(count_in), .detect_out(detect_out), .wrap_out(wrap_out),
    .run_stop(run_stop), .irq(irq)
  );
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) q.push_back(exp);
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  // Pin edges with a random idle gap, each level held well above two cycles
  task automatic pulse(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      @(posedge pclk);
      count_in <= 1'b1;
      repeat (3) @(posedge pclk);
      count_in <= 1'b0;
      repeat (3 + xs() % 4) @(posedge pclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Result watcher: read data against the oldest note, wrap pulse shape
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp({pslverr, prdata}, q.pop_front());
    if (wrap_out === 1'b1) begin
      wraps++;
      cmp({32'h0, detect_out}, 33'h0);
      if (wrap_prev === 1'b1) cmp(33'h1, 33'h0);
    end
    wrap_prev <= wrap_out;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_MODE, 32'h103);
    rd(OFS_WRAP, 32'h1);
    rd(OFS_DETECT, 32'h1);
    rd(OFS_TARGET, 32'h0);
    apb(1'b0, 12'h028, 32'h0, {1'b1, 32'h0});
    wr(OFS_MODE, 32'h0004);
    rd(OFS_MODE, 32'h103);
    wr(OFS_MODE, 32'h0503);
    rd(OFS_MODE, 32'h103);
    wr(OFS_WRAP, 32'h2710);
    rd(OFS_WRAP, 32'h1);
    wr(OFS_WRAP, 32'h270F);
    rd(OFS_WRAP, 32'h270F);
    wr(OFS_TARGET, 32'h2710);
    rd(OFS_TARGET, 32'h0);
    $display("test registers done");
    det = 16'(xs() % 7 + 1);
    wr(OFS_WRAP, 32'h8);
    wr(OFS_DETECT, {16'h0, det});
    wr(OFS_DETECT, 32'h9);
    rd(OFS_DETECT, {16'h0, det});
    pulse(det - 1);
    rd(OFS_COUNT, 32'(det - 1));
    cmp({32'h0, detect_out}, 33'h0);
    pulse(1);
    cmp({32'h0, detect_out}, 33'h1);
    pulse(7 - det);
    rd(OFS_COUNT, 32'h7);
    cmp({32'h0, detect_out}, 33'h1);
    pulse(1);
    rd(OFS_COUNT, 32'h0);
    cmp(33'(wraps), 33'h1);
    cmp({32'h0, detect_out}, 33'h0);
    cmp({32'h0, run_stop}, 33'h0);
    pulse(1);
    rd(OFS_COUNT, 32'h1);
    $display("test cyclic counter done");
    rd(OFS_IRQ_STAT, 32'h3);
    cmp({32'h0, irq}, 33'h0);
    wr(OFS_IRQ_MASK, 32'h2);
    @(posedge pclk);
    cmp({32'h0, irq}, 33'h1);
    wr(OFS_IRQ_STAT, 32'h2);
    @(posedge pclk);
    cmp({32'h0, irq}, 33'h0);
    rd(OFS_IRQ_STAT, 32'h1);
    $display("test interrupt done");
    wr(OFS_MODE, 32'h0100);
    pulse(7);
    cmp(33'(wraps), 33'h2);
    cmp({32'h0, run_stop}, 33'h1);
    pulse(2);
    rd(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'h1);
    @(posedge pclk);
    cmp({32'h0, run_stop}, 33'h0);
    pulse(1);
    rd(OFS_COUNT, 32'h1);
    $display("test one-shot counter done");
    wr(OFS_TARGET, 32'h2);
    wr(OFS_MODE, 32'h0000);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h4);
    wr(OFS_CTRL, 32'h2);
    n = 0;
    while (run_stop !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    cmp({32'h0, (n >= 2 * TICKS - 4 && n <= 2 * TICKS + 4)}, 33'h1);
    cmp({32'h0, irq}, 33'h1);
    wr(OFS_IRQ_STAT, 32'h4);
    repeat (4 * TICKS) @(posedge pclk);
    cmp({32'h0, irq}, 33'h0);
    $display("test timer done");
    wr(OFS_TARGET, 32'h1);
    wr(OFS_MODE, 32'h0300);
    wr(OFS_CTRL, 32'h2);
    repeat (3 * TICKS) @(posedge pclk);
    rd(OFS_STATUS, {31'h0, det == 16'h0001});
    wr(OFS_IRQ_STAT, 32'h4);
    repeat (2 * TICKS) @(posedge pclk);
    rd(OFS_IRQ_STAT, 32'h4);
    cmp({32'h0, run_stop}, 33'h0);
    $display("test cyclic timer done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_MODE, 32'h103);
    rd(OFS_WRAP, 32'h1);
    rd(OFS_DETECT, 32'h1);
    rd(OFS_IRQ_STAT, 32'h0);
    cmp({32'h0, run_stop}, 33'h0);
    $display("test reset in run done");
    give_verdict();
  end
endmodule
`default_nettype wire
